// *** verilog/hub_product_id_config_defs.vh ***
// Register offsets, field positions, reset values and selection codes for the hub product code configuration.
`ifndef HUB_PRODUCT_ID_CONFIG_DEFS_VH
`define HUB_PRODUCT_ID_CONFIG_DEFS_VH
`define PCHB_OFFSET 4'h4
`define HFC_OFFSET 4'h5
`define PCHB_RESET 8'h80 // Arbitrary value, not a real maker code.
`define HFC_RESET 8'h10
`define HFC_RSVD_MASK 8'h11
`define HFC_RSVD_VALUE 8'h10
`define HFC_STRING_BIT 7
`define HFC_SERIAL_BIT 6
`define HFC_INHIBIT_BIT 5
`define HFC_GANGED_BIT 3
`define HFC_FULLPWR_BIT 2
`define HFC_TIMER_BIT 1
`define SRC_CONFIG 2'h0
`define SRC_OTP 2'h1
`define SRC_DEFAULT 2'h2
`endif

// *** verilog/product_code_select.v ***
// Chooses the effective product code high byte from configured, one-time-programmable and built-in values.
`timescale 1ns/10ps
`default_nettype none
`include "hub_product_id_config_defs.vh"
module product_code_select #(
  parameter [7:0] BUILTIN_VALUE = 8'h80 // Arbitrary value, not a real maker code.
) (
  input wire clock,
  input wire rst,
  input wire enable,
  input wire [7:0] config_value,
  input wire config_both_zero,
  input wire [7:0] otp_value,
  output reg [7:0] effective_value,
  output reg [1:0] source
);
  // =========================================================
  // Source priority
  // =========================================================
  // Registered selection so the effective byte comes straight from a flip-flop.
  always @(posedge clock) begin
    if (rst) begin
      effective_value <= BUILTIN_VALUE;
      source <= `SRC_DEFAULT;
    end else if (enable) begin
      if (!config_both_zero) begin
        effective_value <= config_value;
        source <= `SRC_CONFIG;
      end else if (otp_value != 8'h00) begin
        effective_value <= otp_value;
        source <= `SRC_OTP;
      end else begin
        effective_value <= BUILTIN_VALUE;
        source <= `SRC_DEFAULT;
      end
    end
  end
endmodule
`default_nettype wire

// *** verilog/hub_product_id_config.v ***
// Product code high byte and hub feature configuration registers with link low-power inhibit control.
`timescale 1ns/10ps
`default_nettype none
`include "hub_product_id_config_defs.vh"
module hub_product_id_config #(
  parameter [7:0] BUILTIN_PRODUCT_HIGH = 8'h80 // Arbitrary value, not a real maker code.
) (
  input wire clock,
  input wire rst,
  input wire clock_enable,
  input wire cfg_write,
  input wire cfg_read,
  input wire [3:0] cfg_address,
  input wire [7:0] cfg_write_data,
  output reg [7:0] cfg_read_data,
  input wire vendor_code_zero,
  input wire [7:0] otp_product_high,
  input wire force_accept_seen,
  input wire upstream_disconnect,
  input wire lpm_request,
  output reg [7:0] effective_product_high,
  output reg [1:0] product_source,
  output reg lpm_allowed,
  output reg string_override_enable,
  output reg serial_override_enable,
  output reg link_low_power_inhibit
);
  // =========================================================
  // Notes for users
  // =========================================================
  // All inputs are taken to come from logic on this clock, so none is synchronised here.
  // The effective byte follows a write to the product register two edges later.
  // The link power grant follows the registered inhibit copy, so it lags a write by two edges.
  // A clock enable held low freezes every register, including the forced-accept latch.

  // =========================================================
  // Register storage
  // =========================================================
  // Stored register values; the top outputs are separate flip-flops below.
  reg [7:0] product_code_high_byte;
  reg [7:0] hub_feature_configuration;
  reg force_accept_latched;
  // Next values worked out combinationally and loaded on the rising edge.
  reg [7:0] next_product_code_high_byte;
  reg [7:0] next_hub_feature_configuration;
  reg [7:0] next_cfg_read_data;
  reg next_force_accept_latched;
  reg next_lpm_allowed;
  // Selector results and decoded strobes.
  wire [7:0] effective_value;
  wire [1:0] source;
  wire product_zero;
  wire config_both_zero;
  wire write_product;
  wire write_feature;
  wire read_strobe;
  wire inhibit_now;

  // =========================================================
  // Helper functions
  // =========================================================
  // Masks reserved bits to their fixed read values.
  // Bit 4 always reads one and bit 0 always reads zero, whatever is written.
  function [7:0] fix_reserved;
    input [7:0] value;
    begin
      fix_reserved = (value & ~`HFC_RSVD_MASK) | `HFC_RSVD_VALUE;
    end
  endfunction

  // True when an access addresses the given register offset.
  // Shared by the write decode and the read multiplexer.
  function hits;
    input [3:0] address;
    input [3:0] offset;
    begin
      hits = (address == offset);
    end
  endfunction

  // =========================================================
  // Access decode
  // =========================================================
  // Strobes count only while the clock enable lets state advance.
  assign write_product = clock_enable && cfg_write && hits(cfg_address, `PCHB_OFFSET);
  assign write_feature = clock_enable && cfg_write && hits(cfg_address, `HFC_OFFSET);
  assign read_strobe = clock_enable && cfg_read;

  // The configured pair counts as zero only when both product and vendor bytes are zero.
  assign product_zero = (product_code_high_byte == 8'h00);
  assign config_both_zero = product_zero && vendor_code_zero;

  // =========================================================
  // Register writes
  // =========================================================
  // Next register values; a write to any other offset leaves both untouched.
  always @* begin
    next_product_code_high_byte = product_code_high_byte;
    next_hub_feature_configuration = hub_feature_configuration;
    if (write_product) begin
      next_product_code_high_byte = cfg_write_data;
    end
    if (write_feature) begin
      next_hub_feature_configuration = fix_reserved(cfg_write_data);
    end
  end

  // Register update; reset loads the default values.
  always @(posedge clock) begin
    if (rst) begin
      product_code_high_byte <= `PCHB_RESET;
      hub_feature_configuration <= `HFC_RESET;
    end else begin
      product_code_high_byte <= next_product_code_high_byte;
      hub_feature_configuration <= next_hub_feature_configuration;
    end
  end

  // =========================================================
  // Read port
  // =========================================================
  // Read multiplexer; unmapped offsets return zero, and the last value holds between reads.
  always @* begin
    next_cfg_read_data = cfg_read_data;
    if (read_strobe) begin
      if (hits(cfg_address, `PCHB_OFFSET)) begin
        next_cfg_read_data = product_code_high_byte;
      end else if (hits(cfg_address, `HFC_OFFSET)) begin
        next_cfg_read_data = hub_feature_configuration;
      end else begin
        next_cfg_read_data = 8'h00;
      end
    end
  end

  // Read data register; a read in the same cycle as a write returns the old value.
  always @(posedge clock) begin
    if (rst) begin
      cfg_read_data <= 8'h00;
    end else begin
      cfg_read_data <= next_cfg_read_data;
    end
  end

  // =========================================================
  // Effective product code
  // =========================================================
  product_code_select #(
    .BUILTIN_VALUE(BUILTIN_PRODUCT_HIGH)
  ) u_select (
    .clock(clock),
    .rst(rst),
    .enable(clock_enable),
    .config_value(product_code_high_byte),
    .config_both_zero(config_both_zero),
    .otp_value(otp_product_high),
    .effective_value(effective_value),
    .source(source)
  );

  // Copies the selection outputs into the top-level output flip-flops.
  always @(posedge clock) begin
    if (rst) begin
      effective_product_high <= BUILTIN_PRODUCT_HIGH;
      product_source <= `SRC_DEFAULT;
    end else if (clock_enable) begin
      effective_product_high <= effective_value;
      product_source <= source;
    end
  end

  // =========================================================
  // Link low-power control
  // =========================================================
  // A forced accept holds U1/U2 allowed until reset or upstream disconnect.
  // When both arrive together the accept wins, so an allowance is never lost silently.
  always @* begin
    next_force_accept_latched = force_accept_latched;
    if (clock_enable) begin
      if (force_accept_seen) begin
        next_force_accept_latched = 1'b1;
      end else if (upstream_disconnect) begin
        next_force_accept_latched = 1'b0;
      end
    end
  end

  // Forced-accept latch register.
  always @(posedge clock) begin
    if (rst) begin
      force_accept_latched <= 1'b0;
    end else begin
      force_accept_latched <= next_force_accept_latched;
    end
  end

  // The registered inhibit copy is used, so the grant lags the visible inhibit bit by one edge, and a forced accept overrides it.
  assign inhibit_now = link_low_power_inhibit && !force_accept_latched && !force_accept_seen;

  // Next grant for a U1/U2 entry request.
  always @* begin
    next_lpm_allowed = lpm_allowed;
    if (clock_enable) begin
      next_lpm_allowed = lpm_request && !inhibit_now;
    end
  end

  // Grant register and the control bits mirrored onto outputs.
  always @(posedge clock) begin
    if (rst) begin
      lpm_allowed <= 1'b0;
      string_override_enable <= 1'b0;
      serial_override_enable <= 1'b0;
      link_low_power_inhibit <= 1'b0;
    end else if (clock_enable) begin
      lpm_allowed <= next_lpm_allowed;
      string_override_enable <= hub_feature_configuration[`HFC_STRING_BIT];
      serial_override_enable <= hub_feature_configuration[`HFC_SERIAL_BIT];
      link_low_power_inhibit <= hub_feature_configuration[`HFC_INHIBIT_BIT];
    end
  end
endmodule
`default_nettype wire

// *** test/hub_product_id_config_assertions.sv ***
// Checker for the product code and feature configuration block.
`timescale 1ns/10ps
`default_nettype none
module hub_product_id_config_assertions #(parameter [7:0] BUILTIN_PRODUCT_HIGH = 8'h80) (
  input wire clock, input wire rst, input wire clock_enable, input wire cfg_write, input wire cfg_read,
  input wire [3:0] cfg_address, input wire [7:0] cfg_write_data, input wire [7:0] cfg_read_data,
  input wire vendor_code_zero, input wire [7:0] otp_product_high, input wire force_accept_seen,
  input wire upstream_disconnect, input wire lpm_request, input wire [7:0] effective_product_high,
  input wire [1:0] product_source, input wire lpm_allowed, input wire link_low_power_inhibit);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  reg forced;
  wire grant = lpm_request && (!link_low_power_inhibit || forced || force_accept_seen);
  // Remembers a forced accept until reset or an upstream disconnect.
  always @(posedge clock) forced <= rst ? 1'b0 : !clock_enable ? forced : force_accept_seen ? 1'b1 : upstream_disconnect ? 1'b0 : forced;
  sequence s_wr; clock_enable && cfg_write && cfg_address == 4'h4; endsequence
  sequence s_hold; (clock_enable && !cfg_write && $stable(otp_product_high) && $stable(vendor_code_zero))[*2]; endsequence
  a_reset_value: assert property (disable iff (1'b0) rst |=> effective_product_high == BUILTIN_PRODUCT_HIGH && product_source == 2'h2) else $error("bad reset value");
  a_write_read: assert property (s_wr ##1 s_hold ##0 cfg_read && cfg_address == 4'h4 |=> cfg_read_data == $past(cfg_write_data, 3)) else $error("bad readback");
  a_config_used: assert property (s_wr ##0 cfg_write_data != 8'h00 ##1 s_hold |=> effective_product_high == $past(cfg_write_data, 3) && product_source == 2'h0) else $error("config byte unused");
  a_otp_used: assert property (s_wr ##0 cfg_write_data == 8'h00 && vendor_code_zero && otp_product_high != 8'h00 ##1 s_hold |=> effective_product_high == $past(otp_product_high) && product_source == 2'h1) else $error("otp byte unused");
  a_builtin_used: assert property (s_wr ##0 cfg_write_data == 8'h00 && vendor_code_zero && otp_product_high == 8'h00 ##1 s_hold |=> effective_product_high == BUILTIN_PRODUCT_HIGH && product_source == 2'h2) else $error("default byte unused");
  a_lpm_grant: assert property (clock_enable |=> lpm_allowed == $past(grant)) else $error("bad link power grant");
endmodule
bind hub_product_id_config hub_product_id_config_assertions #(.BUILTIN_PRODUCT_HIGH(BUILTIN_PRODUCT_HIGH)) checker_i (.clock, .rst, .clock_enable, .cfg_write, .cfg_read, .cfg_address, .cfg_write_data, .cfg_read_data, .vendor_code_zero, .otp_product_high, .force_accept_seen, .upstream_disconnect, .lpm_request, .effective_product_high, .product_source, .lpm_allowed, .link_low_power_inhibit);
`default_nettype wire

// *** test/config_source_model.sv ***
// Configuration source that loads and reads the hub registers.
`timescale 1ns/10ps
`default_nettype none
module config_source_model (input wire logic clock, output logic cfg_write, output logic cfg_read,
  output logic [3:0] cfg_address, output logic [7:0] cfg_write_data);
  initial {cfg_write, cfg_read, cfg_address, cfg_write_data} = '0;
  // One access held across one rising edge; released data is inverted so it never looks valid.
  task access(input bit wr, input logic [3:0] a, input logic [7:0] d);
    @(negedge clock);
    {cfg_write, cfg_read, cfg_address, cfg_write_data} = {wr, !wr, a, d};
    @(negedge clock);
    {cfg_write, cfg_read, cfg_write_data} = {2'h0, ~d};
  endtask
endmodule
`default_nettype wire

// *** test/hub_product_id_config_tb.sv ***
// Self-checking bench for the product code and feature configuration block.
`timescale 1ns/10ps
`default_nettype none
module hub_product_id_config_tb;
  logic clock = 0, rst = 1, clock_enable = 1, vendor_code_zero = 0, force_accept_seen = 0;
  logic upstream_disconnect = 0, lpm_request = 0, rd_seen = 0, cfg_write, cfg_read, lpm_allowed;
  logic [3:0] cfg_address;
  logic [7:0] cfg_write_data, cfg_read_data, otp_product_high = 8'h00, effective_product_high, d;
  logic [1:0] product_source;
  logic string_override_enable, serial_override_enable, link_low_power_inhibit;
  logic [7:0] notes[$];
  integer miscompares = 0, tests_run = 0, seed = 32'h5d6a_4880;
  always #5 clock = ~clock;
  config_source_model config_source_model_i (.clock, .cfg_write, .cfg_read, .cfg_address, .cfg_write_data);
  hub_product_id_config hub_product_id_config_i (.clock, .rst, .clock_enable, .cfg_write, .cfg_read,
    .cfg_address, .cfg_write_data, .cfg_read_data, .vendor_code_zero, .otp_product_high, .force_accept_seen,
    .upstream_disconnect, .lpm_request, .effective_product_high, .product_source, .lpm_allowed,
    .string_override_enable, .serial_override_enable, .link_low_power_inhibit);
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    notes.push_back(e);
    config_source_model_i.access(0, a, 8'h00);
  endtask
  // Read data shows one edge after the read and is matched with the oldest note.
  always @(posedge clock) rd_seen <= cfg_read && clock_enable;
  always @(negedge clock) if (rd_seen) chk("read data", notes.pop_front(), cfg_read_data);
  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog for a hung run.
  initial begin
    #20000 miscompares++;
    finish_test;
  end
  // Main sequence.
  initial begin
    repeat (20) @(negedge clock);
    rst = 0;
    rd(4'h4, 8'h80);
    rd(4'h5, 8'h10);
    rd(4'h9, 8'h00);
    repeat (4) begin
      d = $random(seed) | 1;
      config_source_model_i.access(1, 4'h4, d);
      rd(4'h4, d);
      repeat (2) @(negedge clock);
      chk("effective", d, effective_product_high);
    end
    vendor_code_zero = 1;
    for (int i = 0; i < 2; i++) begin
      otp_product_high = i ? 8'h00 : d;
      config_source_model_i.access(1, 4'h4, 8'h00);
      repeat (3) @(negedge clock);
      chk("effective", i ? 8'h80 : d, effective_product_high);
      chk("source", i ? 8'h02 : 8'h01, {6'h00, product_source});
    end
    config_source_model_i.access(1, 4'h5, 8'hff);
    rd(4'h5, 8'hfe);
    chk("string enable", 8'h01, {7'h00, string_override_enable});
    chk("serial enable", 8'h01, {7'h00, serial_override_enable});
    chk("inhibit", 8'h01, {7'h00, link_low_power_inhibit});
    lpm_request = 1;
    @(negedge clock) chk("grant", 8'h00, {7'h00, lpm_allowed});
    force_accept_seen = 1;
    @(negedge clock) force_accept_seen = 0;
    @(negedge clock) chk("grant", 8'h01, {7'h00, lpm_allowed});
    upstream_disconnect = 1;
    repeat (2) @(negedge clock);
    chk("grant", 8'h00, {7'h00, lpm_allowed});
    finish_test;
  end
endmodule
`default_nettype wire
